// file: fmp_pkg.sv
// Constants for the mode, ident and perpendicular configuration block
package fmp_pkg;
    // APB register offsets
    localparam logic [7:0] FMP_OFF_CMD = 8'h00;
    localparam logic [7:0] FMP_OFF_STATUS = 8'h04;
    localparam logic [7:0] FMP_OFF_SWRST = 8'h08;
    localparam logic [7:0] FMP_OFF_CFG = 8'h0c;
    localparam logic [7:0] FMP_OFF_RATE = 8'h10;
    localparam logic [7:0] FMP_OFF_GAP = 8'h14;
    // Opcodes
    localparam logic [7:0] FMP_OP_MODE = 8'h01;
    localparam logic [7:0] FMP_OP_IDENT = 8'h18;
    localparam logic [7:0] FMP_OP_PERP = 8'h12;
    localparam logic [7:0] FMP_INVALID_RESULT = 8'h80;
    localparam logic [2:0] FMP_MODE_LAST_IDX = 3'h4;
    localparam logic [2:0] FMP_MODE_SETTLE_IDX = 3'h3;
    // Second perpendicular byte fields
    localparam int FMP_OW_BIT = 7;
    localparam int FMP_DC_LSB = 2;
    localparam int FMP_GAP_BIT = 1;
    localparam int FMP_WG_BIT = 0;
    // Last mode byte fields
    localparam int FMP_RG_BIT = 2;
    localparam int FMP_PU_BIT = 0;
    // Reset values
    localparam logic [3:0] FMP_SETTLE_RST = 4'h8;
    localparam logic [3:0] FMP_DC_RST = 4'h0;
    localparam logic [2:0] FMP_RATE_RST = 3'h2;
    // Data rate codes
    localparam logic [2:0] FMP_RATE_250K = 3'h0;
    localparam logic [2:0] FMP_RATE_300K = 3'h1;
    localparam logic [2:0] FMP_RATE_500K = 3'h2;
    localparam logic [2:0] FMP_RATE_1M = 3'h3;
    localparam logic [2:0] FMP_RATE_2M = 3'h4;
    // Settle multipliers in units of one third of a millisecond
    localparam logic [4:0] FMP_MUL_250K = 5'h18;
    localparam logic [4:0] FMP_MUL_300K = 5'h14;
    localparam logic [4:0] FMP_MUL_500K = 5'h0c;
    localparam logic [4:0] FMP_MUL_1M = 5'h06;
    // Post-ID gap lengths in bytes
    localparam logic [7:0] FMP_GAP_STD = 8'h16;
    localparam logic [7:0] FMP_GAP_PERP_HI = 8'h29;
    localparam logic [7:0] FMP_RW_NONE = 8'h00;
    localparam logic [7:0] FMP_RW_PERP_LO = 8'h13;
    localparam logic [7:0] FMP_RW_PERP_HI = 8'h26;
    // Timing
    localparam int FMP_CLK_PERIOD_NS = 25;
    localparam int FMP_SETTLE_UNIT_NS = 333333;
    localparam int FMP_SETTLE_UNIT_CYC =
        (FMP_SETTLE_UNIT_NS + FMP_CLK_PERIOD_NS - 1) / FMP_CLK_PERIOD_NS;
    typedef enum logic [1:0] {FMP_IDLE, FMP_MODE_BYTES, FMP_PERP_BYTE} fmp_state_t;
endpackage

// file: fmp_mode_perp_cfg.sv
// Mode tail, ident query and perpendicular mode configuration logic
//
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module fmp_mode_perp_cfg
    import fmp_pkg::*;
#(
    parameter int SETTLE_UNIT_CYC = FMP_SETTLE_UNIT_CYC,
    parameter logic [7:0] IDENT_BYTE = 8'h5a // Arbitrary identification value
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic disk_change_input,
    output logic disk_change_status,
    output logic ext_read_gate,
    input wire logic encoded_wdata,
    input wire logic serial_data_in,
    output logic write_data_pin,
    input wire logic [1:0] drive_sel,
    input wire logic seek_sense_done,
    output logic settle_busy,
    output logic settle_done,
    output logic [7:0] post_id_gap_fmt_len,
    output logic [7:0] post_id_gap_rewrite_len,
    output logic precomp_zero
);

    ////////////////////////////////////////////////////////////////////////
    // APB slave, one wait state
    logic ack, result_valid, mapped, acc, wr_cmd, rd_cmd, soft_rst, perp_take;
    logic read_gate_diag_bit, pump_output_diag_bit, gap_len_select_bit, write_gate_select_bit;
    logic drive_perp, high_rate, dchg_meta, dchg_sync, unit_tick;
    logic [7:0] result_byte, cmd_byte;
    logic [3:0] settle_mult, per_drive_perp_select;
    logic [2:0] data_rate, byte_idx;
    logic [15:0] unit_cnt;
    logic [8:0] units_left;
    fmp_state_t state;
    logic [31:0] next_rdata;
    default clocking fmp_cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    assign acc = psel && penable && !ack;
    assign pready = ack;
    assign mapped = paddr == FMP_OFF_CMD || paddr == FMP_OFF_STATUS || paddr == FMP_OFF_SWRST
        || paddr == FMP_OFF_CFG || paddr == FMP_OFF_RATE || paddr == FMP_OFF_GAP;
    assign wr_cmd = ack && pwrite && paddr == FMP_OFF_CMD;
    assign rd_cmd = ack && !pwrite && paddr == FMP_OFF_CMD;
    assign soft_rst = ack && pwrite && paddr == FMP_OFF_SWRST && pwdata[0];
    assign cmd_byte = pwdata[7:0];

    always_comb begin
        next_rdata = 32'h0;
        case (paddr)
            FMP_OFF_CMD: next_rdata = {24'h0, result_byte};
            FMP_OFF_STATUS: next_rdata = {30'h0, state != FMP_IDLE, result_valid};
            FMP_OFF_CFG: next_rdata = {19'h0, settle_mult, 1'b0, read_gate_diag_bit,
                pump_output_diag_bit, per_drive_perp_select, gap_len_select_bit,
                write_gate_select_bit};
            FMP_OFF_RATE: next_rdata = {29'h0, data_rate};
            FMP_OFF_GAP: next_rdata = {15'h0, precomp_zero, post_id_gap_rewrite_len,
                post_id_gap_fmt_len};
            default: next_rdata = 32'h0;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ack <= 1'b0;
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else begin
            ack <= acc;
            if (acc) begin
                prdata <= pwrite ? 32'h0 : next_rdata;
                pslverr <= !mapped;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            data_rate <= FMP_RATE_RST;
        end else if (ack && pwrite && paddr == FMP_OFF_RATE) begin
            data_rate <= pwdata[2:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Command parser
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state <= FMP_IDLE;
            byte_idx <= 3'h0;
        end else if (soft_rst) begin
            state <= FMP_IDLE;
            byte_idx <= 3'h0;
        end else if (wr_cmd && !result_valid) begin
            case (state)
                FMP_IDLE: begin
                    byte_idx <= 3'h1;
                    if (cmd_byte == FMP_OP_MODE) begin
                        state <= FMP_MODE_BYTES;
                    end else if (cmd_byte == FMP_OP_PERP) begin
                        state <= FMP_PERP_BYTE;
                    end
                end
                FMP_MODE_BYTES: begin
                    byte_idx <= byte_idx + 3'h1;
                    if (byte_idx == FMP_MODE_LAST_IDX) begin
                        state <= FMP_IDLE;
                    end
                end
                FMP_PERP_BYTE: state <= FMP_IDLE;
                default: state <= FMP_IDLE;
            endcase
        end
    end

    // Result byte: ident answer or invalid opcode
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            result_valid <= 1'b0;
            result_byte <= 8'h0;
        end else if (soft_rst) begin
            result_valid <= 1'b0;
        end else if (wr_cmd && !result_valid && state == FMP_IDLE
            && cmd_byte != FMP_OP_MODE && cmd_byte != FMP_OP_PERP) begin
            result_valid <= 1'b1;
            result_byte <= cmd_byte == FMP_OP_IDENT ? IDENT_BYTE : FMP_INVALID_RESULT;
        end else if (rd_cmd) begin
            result_valid <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            settle_mult <= FMP_SETTLE_RST;
            read_gate_diag_bit <= 1'b0;
            pump_output_diag_bit <= 1'b0;
        end else if (wr_cmd && !soft_rst && state == FMP_MODE_BYTES) begin
            if (byte_idx == FMP_MODE_SETTLE_IDX) begin
                settle_mult <= cmd_byte[3:0];
            end
            if (byte_idx == FMP_MODE_LAST_IDX) begin
                read_gate_diag_bit <= cmd_byte[FMP_RG_BIT];
                pump_output_diag_bit <= cmd_byte[FMP_PU_BIT];
            end
        end
    end

    // Perpendicular byte loads the gap pair; drive bits only when OW is set
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            per_drive_perp_select <= FMP_DC_RST;
            gap_len_select_bit <= 1'b0;
            write_gate_select_bit <= 1'b0;
        end else if (soft_rst) begin
            // Keep drive bits, clear gap pair
            gap_len_select_bit <= 1'b0;
            write_gate_select_bit <= 1'b0;
        end else if (wr_cmd && state == FMP_PERP_BYTE) begin
            if (cmd_byte[FMP_OW_BIT]) begin
                per_drive_perp_select <= cmd_byte[FMP_DC_LSB +: 4];
            end
            gap_len_select_bit <= cmd_byte[FMP_GAP_BIT];
            write_gate_select_bit <= cmd_byte[FMP_WG_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Gap lengths and precompensation
    assign drive_perp = per_drive_perp_select[drive_sel];
    assign high_rate = data_rate == FMP_RATE_1M || data_rate == FMP_RATE_2M;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            post_id_gap_fmt_len <= FMP_GAP_STD;
            post_id_gap_rewrite_len <= FMP_RW_NONE;
            precomp_zero <= 1'b0;
        end else begin
            precomp_zero <= drive_perp;
            case ({gap_len_select_bit, write_gate_select_bit})
                2'b01: begin
                    post_id_gap_fmt_len <= FMP_GAP_STD;
                    post_id_gap_rewrite_len <= FMP_RW_PERP_LO;
                end
                2'b11: begin
                    post_id_gap_fmt_len <= FMP_GAP_PERP_HI;
                    post_id_gap_rewrite_len <= FMP_RW_PERP_HI;
                end
                2'b10: begin
                    post_id_gap_fmt_len <= FMP_GAP_STD;
                    post_id_gap_rewrite_len <= FMP_RW_NONE;
                end
                default: begin
                    post_id_gap_fmt_len <= drive_perp && high_rate ? FMP_GAP_PERP_HI
                        : FMP_GAP_STD;
                    post_id_gap_rewrite_len <= !drive_perp ? FMP_RW_NONE
                        : (high_rate ? FMP_RW_PERP_HI : FMP_RW_PERP_LO);
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Diagnostic pin routing
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            dchg_meta <= 1'b0;
            dchg_sync <= 1'b0;
        end else begin
            dchg_meta <= disk_change_input;
            dchg_sync <= dchg_meta;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            disk_change_status <= 1'b0;
            ext_read_gate <= 1'b0;
            write_data_pin <= 1'b0;
        end else begin
            // Disk change or external read gate
            disk_change_status <= read_gate_diag_bit ? 1'b0 : dchg_sync;
            ext_read_gate <= read_gate_diag_bit ? dchg_sync : 1'b0;
            // Write data or serial data in
            write_data_pin <= pump_output_diag_bit ? serial_data_in : encoded_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Head settle timer
    function automatic logic [4:0] fmp_rate_mul(input logic [2:0] rate);
        case (rate)
            FMP_RATE_250K: fmp_rate_mul = FMP_MUL_250K;
            FMP_RATE_300K: fmp_rate_mul = FMP_MUL_300K;
            FMP_RATE_500K: fmp_rate_mul = FMP_MUL_500K;
            default: fmp_rate_mul = FMP_MUL_1M;
        endcase
    endfunction

    assign unit_tick = unit_cnt == 16'(SETTLE_UNIT_CYC - 1);

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            unit_cnt <= 16'h0;
            units_left <= 9'h0;
            settle_busy <= 1'b0;
            settle_done <= 1'b0;
        end else begin
            settle_done <= 1'b0;
            if (seek_sense_done && !settle_busy) begin
                // Start settle after seek and sense
                unit_cnt <= 16'h0;
                units_left <= 9'(settle_mult) * 9'(fmp_rate_mul(data_rate));
                settle_busy <= 1'b1;
            end else if (settle_busy) begin
                if (units_left == 9'h0) begin
                    settle_busy <= 1'b0;
                    settle_done <= 1'b1;
                end else if (unit_tick) begin
                    unit_cnt <= 16'h0;
                    units_left <= units_left - 9'h1;
                end else begin
                    unit_cnt <= unit_cnt + 16'h1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    assign perp_take = wr_cmd && state == FMP_PERP_BYTE && !soft_rst;
    a_ow_keep_bits: assert property (perp_take && !cmd_byte[FMP_OW_BIT]
        |=> $stable(per_drive_perp_select)) else $error("drive bits changed");
    a_ow_load_bits: assert property (perp_take && cmd_byte[FMP_OW_BIT]
        |=> per_drive_perp_select == $past(cmd_byte[5:2])) else $error("drive bits not loaded");
    a_soft_clear_gap: assert property (soft_rst
        |=> !gap_len_select_bit && !write_gate_select_bit && $stable(per_drive_perp_select))
        else $error("soft reset handling wrong");
    a_precomp_forced: assert property (drive_perp && $stable(drive_sel)
        && $stable(per_drive_perp_select) |=> precomp_zero) else $error("precomp not zero");
    a_gap_override_hi: assert property (gap_len_select_bit && write_gate_select_bit
        ##1 gap_len_select_bit |-> post_id_gap_fmt_len == FMP_GAP_PERP_HI
        && post_id_gap_rewrite_len == FMP_RW_PERP_HI) else $error("gap override lengths wrong");
    a_conv_gap_len: assert property (!gap_len_select_bit && !write_gate_select_bit
        && !drive_perp |=> post_id_gap_fmt_len == FMP_GAP_STD
        && post_id_gap_rewrite_len == FMP_RW_NONE) else $error("conventional gap lengths wrong");
    a_ident_answer: assert property (wr_cmd && !soft_rst && !result_valid
        && state == FMP_IDLE && cmd_byte == FMP_OP_IDENT |=> result_valid
        && result_byte == IDENT_BYTE && state == FMP_IDLE) else $error("ident result missing");
    a_perp_no_result: assert property (perp_take |=> !result_valid && state == FMP_IDLE)
        else $error("perpendicular command gave a result");
    a_rg_gate_route: assert property (!read_gate_diag_bit |=> !ext_read_gate)
        else $error("read gate active in normal mode");
    a_pu_pin_route: assert property (pump_output_diag_bit
        |=> write_data_pin == $past(serial_data_in)) else $error("pump diagnostic routing wrong");
    a_mult_load: assert property (wr_cmd && !soft_rst && state == FMP_MODE_BYTES
        && byte_idx == FMP_MODE_SETTLE_IDX |=> settle_mult == $past(cmd_byte[3:0]))
        else $error("settle multiplier not loaded");
    a_settle_start: assert property (seek_sense_done && !settle_busy
        |=> settle_busy && !settle_done) else $error("settle wait not started");
endmodule
`default_nettype wire

// file: fmp_host_model.sv
// Host model issuing APB transfers and command bytes to the configuration block
`timescale 1ns/1ps
`default_nettype none
module fmp_host_model
    import fmp_pkg::*;
(
    input wire logic clk_sys,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    output logic hang
);
    int slow = 0;
    logic last_err = 1'h0;

    initial begin
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        hang = 1'h0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // One transfer held until pready; released lines show the inverse
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r);
        int n;
        repeat (slow + 1) @(posedge clk_sys);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'h1 && n < 64);
        r = prdata;
        last_err = pslverr;
        if (n >= 64) hang <= 1'h1;
        psel <= 1'h0;
        penable <= 1'h0;
        pwrite <= ~w;
        paddr <= ~a;
        pwdata <= ~d;
    endtask

    task automatic perp_cmd(input logic [7:0] arg);
        logic [31:0] r;
        xfer(1'h1, FMP_OFF_CMD, {24'h0, FMP_OP_PERP}, r);
        xfer(1'h1, FMP_OFF_CMD, {24'h0, arg}, r);
    endtask
endmodule
`default_nettype wire

// file: test_fdc_mode_perpendicular_config.sv
// Self-checking testbench for the mode and perpendicular configuration block
`timescale 1ns/1ps
`default_nettype none
module test_fdc_mode_perpendicular_config
    import fmp_pkg::*;
;
    localparam int UNIT = 4;
    localparam logic [7:0] ID_BYTE = 8'h3c; // Arbitrary identification value
    logic clk_sys, rstn, psel, penable, pwrite, pready, pslverr, hang;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic disk_change_input, disk_change_status, ext_read_gate, encoded_wdata;
    logic serial_data_in, write_data_pin, seek_sense_done, settle_busy, settle_done;
    logic precomp_zero;
    logic [1:0] drive_sel;
    logic [7:0] fmt_len, rw_len;
    int miscompares, cmp_count, i;
    int muls [4] = '{24, 20, 12, 6};

    fmp_mode_perp_cfg #(.SETTLE_UNIT_CYC(UNIT), .IDENT_BYTE(ID_BYTE)) dut_u (
        .clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .disk_change_input(disk_change_input), .disk_change_status(disk_change_status),
        .ext_read_gate(ext_read_gate), .encoded_wdata(encoded_wdata),
        .serial_data_in(serial_data_in), .write_data_pin(write_data_pin),
        .drive_sel(drive_sel), .seek_sense_done(seek_sense_done), .settle_busy(settle_busy),
        .settle_done(settle_done), .post_id_gap_fmt_len(fmt_len),
        .post_id_gap_rewrite_len(rw_len), .precomp_zero(precomp_zero));

    fmp_host_model host_u (
        .clk_sys(clk_sys), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .hang(hang));

    initial begin
        clk_sys = 1'h0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] cfg_word(logic [3:0] mul, logic rg, logic pu,
                                             logic [3:0] dc, logic [1:0] pair);
        return {19'h0, mul, 1'h0, rg, pu, dc, pair};
    endfunction

    function automatic logic [31:0] gap_word(logic pz, logic [7:0] fmt, logic [7:0] rw);
        return {15'h0, pz, rw, fmt};
    endfunction

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic finish_test();
        if (miscompares == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        host_u.xfer(1'h1, a, d, x);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
        logic [31:0] x;
        host_u.xfer(1'h0, a, 32'h0, x);
        chk(name, x, exp);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic settle(input int m);
        int n;
        @(posedge clk_sys);
        seek_sense_done <= 1'h1;
        @(posedge clk_sys);
        seek_sense_done <= 1'h0;
        #1;
        chk("settle busy", {31'h0, settle_busy}, 32'h1);
        n = 1;
        while (settle_done !== 1'h1 && n < 1000) begin
            tick(1);
            n++;
        end
        chk("settle time", 32'(n >= m * UNIT && n <= m * (UNIT + 1) + 4), 32'h1);
        if (n >= 1000) finish_test();
    endtask

    always @(posedge hang) begin
        miscompares++;
        finish_test();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rstn = 1'h0;
        disk_change_input = 1'h0;
        encoded_wdata = 1'h0;
        serial_data_in = 1'h0;
        drive_sel = 2'h0;
        seek_sense_done = 1'h0;
        miscompares = 0;
        cmp_count = 0;
        repeat (8) @(posedge clk_sys);
        rstn <= 1'h1;
        rd(FMP_OFF_CFG, cfg_word(4'h8, 0, 0, 4'h0, 2'h0), "cfg reset");
        rd(FMP_OFF_GAP, gap_word(0, FMP_GAP_STD, FMP_RW_NONE), "gap reset");
        disk_change_input <= 1'h1;
        encoded_wdata <= 1'h1;
        tick(4);
        chk("disk change", {31'h0, disk_change_status}, 32'h1);
        chk("read gate", {31'h0, ext_read_gate}, 32'h0);
        chk("write pin", {31'h0, write_data_pin}, 32'h1);
        wr(FMP_OFF_CMD, {24'h0, FMP_OP_IDENT});
        rd(FMP_OFF_STATUS, 32'h1, "ident pending");
        rd(FMP_OFF_CMD, {24'h0, ID_BYTE}, "ident byte");
        rd(FMP_OFF_STATUS, 32'h0, "ident taken");
        host_u.slow = 2;
        host_u.perp_cmd(8'h94);
        host_u.slow = 0;
        rd(FMP_OFF_STATUS, 32'h0, "perp no result");
        rd(FMP_OFF_CFG, cfg_word(4'h8, 0, 0, 4'h5, 2'h0), "drive bits");
        for (i = 0; i < 5; i++) begin
            wr(FMP_OFF_RATE, 32'(i));
            rd(FMP_OFF_GAP, (i >= 3) ? gap_word(1, FMP_GAP_PERP_HI, FMP_RW_PERP_HI) :
               gap_word(1, FMP_GAP_STD, FMP_RW_PERP_LO), "perp rate");
        end
        drive_sel <= 2'h1;
        rd(FMP_OFF_GAP, gap_word(0, FMP_GAP_STD, FMP_RW_NONE), "conv drive");
        chk("fmt pin", {24'h0, fmt_len}, {24'h0, FMP_GAP_STD});
        chk("rewrite pin", {24'h0, rw_len}, {24'h0, FMP_RW_NONE});
        host_u.perp_cmd(8'h3c);
        rd(FMP_OFF_CFG, cfg_word(4'h8, 0, 0, 4'h5, 2'h0), "no overwrite");
        for (i = 1; i < 4; i++) begin
            host_u.perp_cmd(8'(i));
            rd(FMP_OFF_GAP, (i == 1) ? gap_word(0, FMP_GAP_STD, FMP_RW_PERP_LO) :
               (i == 2) ? gap_word(0, FMP_GAP_STD, FMP_RW_NONE) :
               gap_word(0, FMP_GAP_PERP_HI, FMP_RW_PERP_HI), "pair");
        end
        wr(FMP_OFF_SWRST, 32'h1);
        rd(FMP_OFF_CFG, cfg_word(4'h8, 0, 0, 4'h5, 2'h0), "soft reset");
        wr(FMP_OFF_CMD, {24'h0, FMP_OP_MODE});
        rd(FMP_OFF_STATUS, 32'h2, "mode in progress");
        wr(FMP_OFF_CMD, 32'h0);
        wr(FMP_OFF_CMD, 32'h0);
        wr(FMP_OFF_CMD, 32'h3);
        wr(FMP_OFF_CMD, 32'h5);
        rd(FMP_OFF_CFG, cfg_word(4'h3, 1, 1, 4'h5, 2'h0), "mode tail");
        encoded_wdata <= 1'h0;
        serial_data_in <= 1'h1;
        tick(4);
        chk("disk change diag", {31'h0, disk_change_status}, 32'h0);
        chk("read gate diag", {31'h0, ext_read_gate}, 32'h1);
        chk("write pin diag", {31'h0, write_data_pin}, 32'h1);
        for (i = 0; i < 4; i++) begin
            wr(FMP_OFF_RATE, 32'(i));
            settle(3 * muls[i]);
        end
        wr(FMP_OFF_CMD, 32'h55);
        rd(FMP_OFF_CMD, {24'h0, FMP_INVALID_RESULT}, "bad opcode");
        host_u.xfer(1'h0, 8'h20, 32'h0, r);
        chk("unmapped data", r, 32'h0);
        chk("unmapped err", {31'h0, host_u.last_err}, 32'h1);
        @(posedge clk_sys);
        rstn <= 1'h0;
        repeat (2) @(posedge clk_sys);
        rstn <= 1'h1;
        rd(FMP_OFF_CFG, cfg_word(4'h8, 0, 0, 4'h0, 2'h0), "hw reset cfg");
        rd(FMP_OFF_GAP, gap_word(0, FMP_GAP_STD, FMP_RW_NONE), "hw reset gap");
        tick(2);
        chk("hw reset pin", {31'h0, write_data_pin}, 32'h0);
        finish_test();
    end
endmodule
`default_nettype wire
